// File: design/crtc_defs.svh
// Offsets, field positions, the control reset value and timing counts for the calendar clock.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef CRTC_DEFS_SVH
`define CRTC_DEFS_SVH
// Register byte offsets
`define CRTC_SEC_OFF      8'h00
`define CRTC_MIN_OFF      8'h04
`define CRTC_HRS_OFF      8'h08
`define CRTC_DOW_OFF      8'h0c
`define CRTC_DOM_OFF      8'h10
`define CRTC_MON_OFF      8'h14
`define CRTC_YR_OFF       8'h18
`define CRTC_CEN_OFF      8'h1c
`define CRTC_ASEC_OFF     8'h20
`define CRTC_AMIN_OFF     8'h24
`define CRTC_AHRS_OFF     8'h28
`define CRTC_ADOW_OFF     8'h2c
`define CRTC_ACTRL_OFF    8'h30
`define CRTC_CTRL_OFF     8'h34
`define CRTC_IMASK_OFF    8'h38
// Control register fields
`define CRTC_CTRL_ALARM   7
`define CRTC_CTRL_INTEN   6
`define CRTC_CTRL_BCD     5
`define CRTC_CTRL_LINE60  4
`define CRTC_CTRL_LINESEL 3
`define CRTC_CTRL_UNLOCK  0
`define CRTC_CTRL_RESET   8'h00
// Prescale counts
`define CRTC_XTAL_HZ      32768
`define CRTC_DIV_XTAL     16'd32767
`define CRTC_DIV_50       16'd49
`define CRTC_DIV_60       16'd59
`endif

// File: design/crtc_pkg.sv
// Types for the calendar clock.
// Assumes crtc_defs.svh holds the register offsets, control fields, control reset value and prescale counts.
package crtc_pkg;
   // ------------------------------------------------------------
   // Bus slave states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CRTC_IDLE = 3'b001,
      CRTC_BRSP = 3'b010,
      CRTC_RRSP = 3'b100
   } crtc_bus_t;
endpackage : crtc_pkg

// File: design/crtc_top.sv
// Calendar clock with alarm, prescaler and AXI4-Lite register slave.
// Assumes one 10 MHz clock; crystal and line inputs arrive asynchronously.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "crtc_defs.svh"
module crtc_top (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Timebase inputs
   input  wire logic        xtal_clk_in,
   input  wire logic        crystal_out_pin,
   // AXI4-Lite write
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // Interrupt
   output logic             irq
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Increment with wrap in the chosen coding; returns {wrapped, value}
   function automatic logic [8:0] inc_wrap(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic bcd);
      logic [7:0] n;
      n = v + 8'h01;
      if (bcd && v[3:0] == 4'h9)
         n = {v[7:4] + 4'h1, 4'h0};
      if (v == hi)
         inc_wrap = {1'b1, lo};
      else
         inc_wrap = {1'b0, n};
   endfunction : inc_wrap

   function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bcd);
      to_bin = bcd ? 8'((v[7:4] * 4'd10) + {4'h0, v[3:0]}) : v;
   endfunction : to_bin

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [2:0] xtal_sync;
   logic [2:0] line_sync;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         xtal_sync <= 3'h0;
         line_sync <= 3'h0;
      end else begin
         xtal_sync <= {xtal_sync[1:0], xtal_clk_in};
         line_sync <= {line_sync[1:0], crystal_out_pin};
      end
   end
   // Edge detect reads only stages two and three
   wire xtal_rise = xtal_sync[1] & ~xtal_sync[2];
   wire line_rise = line_sync[1] & ~line_sync[2];

   // ------------------------------------------------------------
   // Registers and bus decode
   // ------------------------------------------------------------
   logic [7:0] ctrl;
   logic [7:0] sec, min, hrs, dow, dom, mon, yr, cen;
   logic [7:0] a_sec, a_min, a_hrs, a_dow;
   logic [3:0] a_en;
   logic       imask;
   logic       tick;
   logic       force_cmp;
   crtc_pkg::crtc_bus_t bstate;
   logic       aw_got, w_got;
   logic [7:0] aw_hold;
   logic [31:0] w_hold;

   logic w_hold_strb0;
   wire unlock = ctrl[`CRTC_CTRL_UNLOCK];
   wire bcd    = ctrl[`CRTC_CTRL_BCD];
   wire do_wr  = (bstate == crtc_pkg::CRTC_IDLE) && aw_got && w_got && w_hold_strb0;
   wire do_rd  = (bstate == crtc_pkg::CRTC_IDLE) && s_arvalid && !(aw_got && w_got);
   wire wr_cnt = do_wr && unlock;
   wire ctrl_wr = do_wr && aw_hold == `CRTC_CTRL_OFF;
   wire ctrl_rd = do_rd && s_araddr == `CRTC_CTRL_OFF;

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bstate       <= crtc_pkg::CRTC_IDLE;
         aw_got       <= 1'b0;
         w_got        <= 1'b0;
         aw_hold      <= 8'h00;
         w_hold       <= 32'h0;
         w_hold_strb0 <= 1'b0;
         s_awready    <= 1'b1;
         s_wready     <= 1'b1;
         s_arready    <= 1'b1;
         s_bvalid     <= 1'b0;
         s_rvalid     <= 1'b0;
         s_bresp      <= 2'h0;
         s_rresp      <= 2'h0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_got    <= 1'b1;
            aw_hold   <= s_awaddr;
            s_awready <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_got        <= 1'b1;
            w_hold       <= s_wdata;
            w_hold_strb0 <= s_wstrb[0];
            s_wready     <= 1'b0;
         end
         unique case (bstate)
            crtc_pkg::CRTC_IDLE: begin
               if (aw_got && w_got) begin
                  aw_got    <= 1'b0;
                  w_got     <= 1'b0;
                  s_bvalid  <= 1'b1;
                  s_bresp   <= (aw_hold > `CRTC_IMASK_OFF || aw_hold[1:0] != 2'h0)
                               ? 2'h2 : 2'h0;
                  s_arready <= 1'b0;
                  bstate    <= crtc_pkg::CRTC_BRSP;
               end else if (s_arvalid) begin
                  s_arready <= 1'b0;
                  s_rvalid  <= 1'b1;
                  s_rresp   <= (s_araddr > `CRTC_IMASK_OFF || s_araddr[1:0] != 2'h0)
                               ? 2'h2 : 2'h0;
                  bstate    <= crtc_pkg::CRTC_RRSP;
               end
            end
            crtc_pkg::CRTC_BRSP: begin
               if (s_bready) begin
                  s_bvalid  <= 1'b0;
                  s_awready <= 1'b1;
                  s_wready  <= 1'b1;
                  s_arready <= 1'b1;
                  bstate    <= crtc_pkg::CRTC_IDLE;
               end
            end
            crtc_pkg::CRTC_RRSP: begin
               if (s_rready) begin
                  s_rvalid  <= 1'b0;
                  s_arready <= 1'b1;
                  bstate    <= crtc_pkg::CRTC_IDLE;
               end
            end
         endcase
      end
   end

   // Read data, captured with the address
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         s_rdata <= 32'h0;
      else if (do_rd) begin
         unique case (s_araddr)
            `CRTC_SEC_OFF:   s_rdata <= {24'h0, sec};
            `CRTC_MIN_OFF:   s_rdata <= {24'h0, min};
            `CRTC_HRS_OFF:   s_rdata <= {24'h0, hrs};
            `CRTC_DOW_OFF:   s_rdata <= {28'h0, dow[3:0]};
            `CRTC_DOM_OFF:   s_rdata <= {24'h0, dom};
            `CRTC_MON_OFF:   s_rdata <= {24'h0, mon};
            `CRTC_YR_OFF:    s_rdata <= {24'h0, yr};
            `CRTC_CEN_OFF:   s_rdata <= {24'h0, cen};
            `CRTC_ASEC_OFF:  s_rdata <= {24'h0, a_sec};
            `CRTC_AMIN_OFF:  s_rdata <= {24'h0, a_min};
            `CRTC_AHRS_OFF:  s_rdata <= {24'h0, a_hrs};
            `CRTC_ADOW_OFF:  s_rdata <= {28'h0, a_dow[3:0]};
            `CRTC_ACTRL_OFF: s_rdata <= {28'h0, a_en};
            `CRTC_CTRL_OFF:  s_rdata <= {24'h0, ctrl};
            `CRTC_IMASK_OFF: s_rdata <= {31'h0, imask};
            default:         s_rdata <= 32'h0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Control register and alarm flag
   // ------------------------------------------------------------
   logic alarm_hit;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl  <= `CRTC_CTRL_RESET;
         imask <= 1'b1;
      end else begin
         if (ctrl_wr)
            ctrl[6:0] <= w_hold[6:0];
         if (do_wr && aw_hold == `CRTC_IMASK_OFF)
            imask <= w_hold[0];
         // Hit beats the read clear so no alarm is lost
         if (alarm_hit)
            ctrl[`CRTC_CTRL_ALARM] <= 1'b1;
         else if (ctrl_rd)
            ctrl[`CRTC_CTRL_ALARM] <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         irq <= 1'b0;
      else
         irq <= (ctrl[`CRTC_CTRL_ALARM] || alarm_hit) && ctrl[`CRTC_CTRL_INTEN]
                && imask && !(ctrl_rd && !alarm_hit);
   end

   // ------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------
   logic [15:0] div_cnt;
   wire [15:0] div_top = !ctrl[`CRTC_CTRL_LINESEL] ? `CRTC_DIV_XTAL :
                         ctrl[`CRTC_CTRL_LINE60] ? `CRTC_DIV_60 : `CRTC_DIV_50;
   wire src_edge = ctrl[`CRTC_CTRL_LINESEL] ? line_rise : xtal_rise;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= 16'h0;
         tick    <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (ctrl_wr || unlock)
            div_cnt <= 16'h0;
         else if (src_edge) begin
            if (div_cnt >= div_top) begin
               div_cnt <= 16'h0;
               tick    <= 1'b1;
            end else
               div_cnt <= div_cnt + 16'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Calendar counters
   // ------------------------------------------------------------
   logic [8:0] s_n, m_n, h_n, w_n, d_n, mo_n, y_n, c_n;
   logic [7:0] dim;
   logic       leap;
   always_comb begin
      leap = bcd && (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                           : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8))
             && (yr != 8'h00 || cen[1:0] == 2'h0 || cen == 8'h20);
      unique case (to_bin(mon, bcd))
         8'd2:                      dim = leap ? 8'd29 : 8'd28;
         8'd4, 8'd6, 8'd9, 8'd11:   dim = 8'd30;
         default:                   dim = 8'd31;
      endcase
      if (bcd)
         dim = {dim[7:0] >= 8'd30 ? 4'h3 : 4'h2, 4'(dim % 8'd10)};
      s_n  = inc_wrap(sec, 8'h00, bcd ? 8'h59 : 8'h3b, bcd);
      m_n  = inc_wrap(min, 8'h00, bcd ? 8'h59 : 8'h3b, bcd);
      h_n  = inc_wrap(hrs, 8'h00, bcd ? 8'h23 : 8'h17, bcd);
      w_n  = inc_wrap(dow, 8'h01, 8'h07, bcd);
      d_n  = inc_wrap(dom, 8'h01, dim, bcd);
      mo_n = inc_wrap(mon, 8'h01, bcd ? 8'h12 : 8'h0c, bcd);
      y_n  = inc_wrap(yr, 8'h00, bcd ? 8'h99 : 8'h63, bcd);
      c_n  = inc_wrap(cen, 8'h00, bcd ? 8'h99 : 8'h63, bcd);
   end

   // Counts are left unreset so they survive a warm reset
   always_ff @(posedge mclk) begin
      if (wr_cnt) begin
         unique case (aw_hold)
            `CRTC_SEC_OFF: sec <= w_hold[7:0];
            `CRTC_MIN_OFF: min <= w_hold[7:0];
            `CRTC_HRS_OFF: hrs <= w_hold[7:0];
            `CRTC_DOW_OFF: dow <= {4'h0, w_hold[3:0]};
            `CRTC_DOM_OFF: dom <= w_hold[7:0];
            `CRTC_MON_OFF: mon <= w_hold[7:0];
            `CRTC_YR_OFF:  yr  <= w_hold[7:0];
            `CRTC_CEN_OFF: cen <= w_hold[7:0];
            default: ;
         endcase
      end else if (tick && !unlock) begin
         sec <= s_n[7:0];
         if (s_n[8]) begin
            min <= m_n[7:0];
            if (m_n[8]) begin
               hrs <= h_n[7:0];
               if (h_n[8]) begin
                  dow <= w_n[7:0];
                  dom <= d_n[7:0];
                  if (d_n[8]) begin
                     mon <= mo_n[7:0];
                     if (mo_n[8]) begin
                        yr <= y_n[7:0];
                        if (y_n[8])
                           cen <= c_n[7:0];
                     end
                  end
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Alarm
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         a_en  <= 4'h0;
         a_sec <= 8'h00;
         a_min <= 8'h00;
         a_hrs <= 8'h00;
         a_dow <= 8'h00;
      end else if (do_wr) begin
         unique case (aw_hold)
            `CRTC_ASEC_OFF:  a_sec <= w_hold[7:0];
            `CRTC_AMIN_OFF:  a_min <= w_hold[7:0];
            `CRTC_AHRS_OFF:  a_hrs <= w_hold[7:0];
            `CRTC_ADOW_OFF:  a_dow <= {4'h0, w_hold[3:0]};
            `CRTC_ACTRL_OFF: a_en  <= w_hold[3:0];
            default: ;
         endcase
      end
   end

   // Compare one cycle after the advance or the forcing write
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         force_cmp <= 1'b0;
      else
         force_cmp <= (tick && !unlock) ||
                      (ctrl_wr && !w_hold[`CRTC_CTRL_UNLOCK]);
   end
   assign alarm_hit = force_cmp &&
                      (!a_en[0] || a_sec == sec) && (!a_en[1] || a_min == min) &&
                      (!a_en[2] || a_hrs == hrs) &&
                      (!a_en[3] || a_dow[3:0] == dow[3:0]);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   flag_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
      alarm_hit |=> ctrl[`CRTC_CTRL_ALARM]) else $error("alarm flag not set");
   flag_rdclr_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ctrl_rd && !alarm_hit |=> !ctrl[`CRTC_CTRL_ALARM] && !irq)
      else $error("read did not clear alarm");
   irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
      irq |-> $past(ctrl[`CRTC_CTRL_INTEN])) else $error("irq without enable");
   lock_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      unlock |=> div_cnt == 16'h0 && !tick) else $error("count moved unlocked");
   div_clr_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ctrl_wr |=> div_cnt == 16'h0) else $error("divider not reset");
   force_cmp_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ctrl_wr && !w_hold[`CRTC_CTRL_UNLOCK] |=> force_cmp) else $error("no forced compare");
   sec_cmp_a: assert property (@(posedge mclk) disable iff (!rst_b)
      tick && !unlock |=> force_cmp) else $error("no per-second compare");
   hour_rng_a: assert property (@(posedge mclk) disable iff (!rst_b)
      tick && !unlock && hrs == (bcd ? 8'h23 : 8'h17) && s_n[8] && m_n[8] |=> hrs == 8'h00)
      else $error("hour did not wrap");
   dow_rng_a: assert property (@(posedge mclk) disable iff (!rst_b)
      tick && !unlock && dow == 8'h07 && s_n[8] && m_n[8] && h_n[8] |=> dow == 8'h01)
      else $error("weekday wrap wrong");
   tick_gap_a: assert property (@(posedge mclk) disable iff (!rst_b)
      tick |=> !tick) else $error("double tick");
   en_reset_a: assert property (@(posedge mclk) $rose(rst_b) |-> a_en == 4'h0)
      else $error("alarm enables not cleared");
endmodule : crtc_top

// File: verification/tb_top.sv
// Self-checking bench for the calendar clock: drives the register bus,
// crystal and line inputs directly and judges what comes back.
// Assumes crtc_top with its AXI4-Lite slave and crtc_defs.svh on the include path.
`timescale 1ns/1ns
`include "crtc_defs.svh"
module tb_top;
   localparam logic [7:0] UNL = 8'h01 << `CRTC_CTRL_UNLOCK;
   localparam logic [7:0] LSEL = 8'h01 << `CRTC_CTRL_LINESEL;
   localparam logic [7:0] L60 = 8'h01 << `CRTC_CTRL_LINE60;
   localparam logic [7:0] BCD = 8'h01 << `CRTC_CTRL_BCD;
   localparam logic [7:0] INTE = 8'h01 << `CRTC_CTRL_INTEN;
   localparam logic [7:0] ALRM = 8'h01 << `CRTC_CTRL_ALARM;
   // Stimulus
   logic        mclk, rst_b, xtal_clk_in, crystal_out_pin;
   logic [7:0]  s_awaddr, s_araddr;
   logic [31:0] s_wdata;
   logic [3:0]  s_wstrb;
   logic        s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   // Responses
   wire logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
   wire logic [1:0]  s_bresp, s_rresp;
   wire logic [31:0] s_rdata;
   int          errors;
   int          checks;
   logic [31:0] rdv;
   logic [1:0]  rsp;

   crtc_top uut (.mclk(mclk), .rst_b(rst_b), .xtal_clk_in(xtal_clk_in),
      .crystal_out_pin(crystal_out_pin), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .irq(irq));

   always #50 mclk = ~mclk;

   // ------------------------------------------------------------
   // Bus and timebase helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge mclk);
      s_awaddr <= a;
      s_wdata <= {24'h000000, d};
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_awready && !aw_done) begin
            aw_done = 1'b1;
            s_awvalid <= 1'b0;
         end
         if (s_wready && !w_done) begin
            w_done = 1'b1;
            s_wvalid <= 1'b0;
         end
      end while (!(s_bvalid && aw_done && w_done));
      rsp = s_bresp;
      s_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      do @(posedge mclk); while (!s_arready);
      s_arvalid <= 1'b0;
      s_rready <= 1'b1;
      do @(posedge mclk); while (!s_rvalid);
      rdv = s_rdata;
      rsp = s_rresp;
      s_rready <= 1'b0;
   endtask : rd

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk(rdv, {24'h000000, exp});
   endtask : rd_chk

   task automatic line_edges(input int n);
      repeat (n) begin
         @(posedge mclk);
         crystal_out_pin <= 1'b1;
         repeat (3) @(posedge mclk);
         crystal_out_pin <= 1'b0;
         repeat (3) @(posedge mclk);
      end
      repeat (8) @(posedge mclk);
   endtask : line_edges

   task automatic xtal_edges(input int n);
      repeat (n) begin
         @(posedge mclk);
         xtal_clk_in <= 1'b1;
         @(posedge mclk);
         xtal_clk_in <= 1'b0;
      end
      repeat (8) @(posedge mclk);
   endtask : xtal_edges

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk(irq, 1'b0);
      rd_chk(`CRTC_CTRL_OFF, 8'h00);
      rd_chk(`CRTC_ACTRL_OFF, 8'h00);
      rd(8'h3c);
      chk(rsp, 2'b10);
      wr(8'h3c, 8'h00);
      chk(rsp, 2'b10);
   endtask : t_reset

   task automatic t_wrap;
      wr(`CRTC_CTRL_OFF, LSEL | L60 | UNL);
      wr(`CRTC_SEC_OFF, 8'h3b);
      wr(`CRTC_MIN_OFF, 8'h3b);
      wr(`CRTC_HRS_OFF, 8'h17);
      wr(`CRTC_DOW_OFF, 8'h07);
      rd_chk(`CRTC_SEC_OFF, 8'h3b);
      wr(`CRTC_CTRL_OFF, LSEL | L60);
      wr(`CRTC_SEC_OFF, 8'h10);
      line_edges(59);
      rd_chk(`CRTC_SEC_OFF, 8'h3b);
      line_edges(1);
      rd_chk(`CRTC_SEC_OFF, 8'h00);
      rd_chk(`CRTC_MIN_OFF, 8'h00);
      rd_chk(`CRTC_HRS_OFF, 8'h00);
      rd_chk(`CRTC_DOW_OFF, 8'h01);
   endtask : t_wrap

   task automatic t_div50;
      wr(`CRTC_CTRL_OFF, LSEL | UNL);
      wr(`CRTC_SEC_OFF, 8'h00);
      wr(`CRTC_CTRL_OFF, LSEL);
      line_edges(30);
      wr(`CRTC_CTRL_OFF, LSEL);
      line_edges(30);
      rd_chk(`CRTC_SEC_OFF, 8'h00);
      line_edges(20);
      rd_chk(`CRTC_SEC_OFF, 8'h01);
   endtask : t_div50

   task automatic t_bcd;
      wr(`CRTC_CTRL_OFF, BCD | LSEL | UNL);
      wr(`CRTC_SEC_OFF, 8'h59);
      wr(`CRTC_MIN_OFF, 8'h09);
      wr(`CRTC_CTRL_OFF, BCD | LSEL);
      line_edges(50);
      rd_chk(`CRTC_SEC_OFF, 8'h00);
      rd_chk(`CRTC_MIN_OFF, 8'h10);
   endtask : t_bcd

   task automatic t_alarm;
      wr(`CRTC_CTRL_OFF, LSEL | UNL);
      wr(`CRTC_SEC_OFF, 8'h00);
      wr(`CRTC_MIN_OFF, 8'h00);
      wr(`CRTC_ASEC_OFF, 8'h01);
      wr(`CRTC_ACTRL_OFF, 8'h01);
      wr(`CRTC_CTRL_OFF, INTE | LSEL);
      rd(`CRTC_CTRL_OFF);
      line_edges(50);
      chk(irq, 1'b1);
      rd_chk(`CRTC_CTRL_OFF, ALRM | INTE | LSEL);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
      rd_chk(`CRTC_CTRL_OFF, INTE | LSEL);
   endtask : t_alarm

   task automatic t_force;
      // Count stays at 00:01 here; line input idle so no tick interferes
      wr(`CRTC_AMIN_OFF, 8'h05);
      wr(`CRTC_ACTRL_OFF, 8'h03);
      rd_chk(`CRTC_AMIN_OFF, 8'h05);
      wr(`CRTC_CTRL_OFF, LSEL);
      repeat (4) @(posedge mclk);
      rd_chk(`CRTC_CTRL_OFF, LSEL);
      wr(`CRTC_ACTRL_OFF, 8'h01);
      wr(`CRTC_CTRL_OFF, LSEL);
      repeat (4) @(posedge mclk);
      chk(irq, 1'b0);
      rd_chk(`CRTC_CTRL_OFF, ALRM | LSEL);
   endtask : t_force

   task automatic t_xtal;
      wr(`CRTC_CTRL_OFF, UNL);
      wr(`CRTC_SEC_OFF, 8'h05);
      wr(`CRTC_CTRL_OFF, 8'h00);
      xtal_edges(`CRTC_XTAL_HZ - 1);
      rd_chk(`CRTC_SEC_OFF, 8'h05);
      xtal_edges(1);
      rd_chk(`CRTC_SEC_OFF, 8'h06);
   endtask : t_xtal

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report

   // Crystal scenario alone needs about 66k cycles
   initial begin
      repeat (80000) @(posedge mclk);
      errors++;
      final_report();
   end

   initial begin
      mclk = 1'b0;
      rst_b = 1'b0;
      xtal_clk_in = 1'b0;
      crystal_out_pin = 1'b0;
      s_awaddr = 8'h00;
      s_araddr = 8'h00;
      s_wdata = 32'h00000000;
      s_wstrb = 4'hf;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
      errors = 0;
      checks = 0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_wrap();
      t_div50();
      t_bcd();
      t_alarm();
      t_force();
      t_xtal();
      final_report();
   end
endmodule : tb_top
